/* msic_core.sv */
// Microstep indexer with per-winding fixed off-time chopping and Wishbone registers
`timescale 1ns/10ps
`include "msic_regs.svh"
module msic_core (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_indexer_clear_n,
    input wire logic i_output_on_n,
    input wire logic i_low_power_req_n,
    input wire logic i_step,
    input wire logic i_overcurrent_trip,
    input wire logic i_overtemp_shutdown,
    input wire logic i_supply_low_lockout,
    input wire logic i_trip_a,
    input wire logic i_trip_b,
    input wire logic i_zero_a,
    input wire logic i_zero_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_at_origin_flag_n,
    output msic_pkg::msic_gates_s o_winding_a_outputs,
    output msic_pkg::msic_gates_s o_winding_b_outputs,
    output logic o_bridge_float,
    output logic [7:0] o_dac_a,
    output logic [7:0] o_dac_b,
    output logic o_sign_a,
    output logic o_sign_b
);
    msic_pkg::msic_state_s s_ff;
    msic_pkg::msic_state_s nxt_s;

    // ----------------------------------------------------------------
    // Sine table and helpers
    // ----------------------------------------------------------------
    // Magnitude for quarter-wave index 0..8 (cosine order)
    function automatic logic [7:0] mag(input logic [3:0] k);
        unique case (k)
            4'h0: mag = 8'h64;
            4'h1: mag = 8'h62;
            4'h2: mag = 8'h5c;
            4'h3: mag = 8'h53;
            4'h4: mag = 8'h47;
            4'h5: mag = 8'h38;
            4'h6: mag = 8'h26;
            4'h7: mag = 8'h14;
            default: mag = 8'h00;
        endcase
    endfunction : mag

    // Winding A follows cosine of position p (0..31, 11.25 degree steps)
    function automatic logic [8:0] cos_at(input logic [4:0] p);
        logic [2:0] q;
        logic [3:0] r;
        q = {1'b0, p[4:3]};
        r = {1'b0, p[2:0]};
        unique case (q[1:0])
            2'h0: cos_at = {1'b0, mag(r)};
            2'h1: cos_at = {(r != 4'h0), mag(4'h8 - r)};
            2'h2: cos_at = {1'b1, mag(r)};
            default: cos_at = {1'b0, mag(4'h8 - r)};
        endcase
    endfunction : cos_at

    function automatic msic_pkg::msic_decay_e decode_decay(input logic [1:0] c);
        unique case (c)
            2'h0: decode_decay = msic_pkg::DEC_SLOW;
            2'h1: decode_decay = msic_pkg::DEC_FAST;
            default: decode_decay = msic_pkg::DEC_MIXED;
        endcase
    endfunction : decode_decay

    logic [4:0] stride;
    logic step_rise;
    logic hold_home;
    logic bridges_off;
    logic [8:0] tgt_a;
    logic [8:0] tgt_b;
    logic [8:0] cur_a;
    logic [8:0] cur_b;
    logic rising_a;
    logic rising_b;
    logic wb_hit;
    msic_pkg::msic_decay_e dec_mode;

    // ----------------------------------------------------------------
    // Chopper of one winding
    // ----------------------------------------------------------------
    function automatic msic_pkg::msic_chop_s chop_next(
        input msic_pkg::msic_chop_s c, input logic trip, input logic zero,
        input logic rising, input logic off, input logic [15:0] toff,
        input logic [15:0] tblank, input logic [15:0] tfast,
        input msic_pkg::msic_decay_e mode
    );
        msic_pkg::msic_chop_s n;
        n = c;
        if (c.blank != 16'h0) begin
            n.blank = c.blank - 16'h1;
        end
        if (c.tmr != 16'h0) begin
            n.tmr = c.tmr - 16'h1;
        end
        if (off) begin
            n.ph = msic_pkg::PH_IDLE;
            n.tmr = 16'h0;
            n.blank = 16'h0;
        end else begin
            unique case (c.ph)
                msic_pkg::PH_IDLE: begin
                    n.ph = msic_pkg::PH_DRIVE;
                    n.blank = tblank;
                end
                msic_pkg::PH_DRIVE: begin
                    if (trip && c.blank == 16'h0) begin
                        n.tmr = toff;
                        if (rising || mode == msic_pkg::DEC_SLOW) begin
                            n.ph = msic_pkg::PH_SLOW;
                        end else begin
                            n.ph = msic_pkg::PH_FAST;
                            if (mode == msic_pkg::DEC_MIXED) begin
                                n.blank = tfast;
                            end
                        end
                    end
                end
                msic_pkg::PH_FAST: begin
                    if (c.tmr <= 16'h1) begin
                        n.ph = msic_pkg::PH_DRIVE;
                        n.blank = tblank;
                    end else if (mode == msic_pkg::DEC_MIXED && c.blank <= 16'h1) begin
                        n.ph = msic_pkg::PH_SLOW;
                    end
                end
                default: begin
                    if (c.tmr <= 16'h1) begin
                        n.ph = msic_pkg::PH_DRIVE;
                        n.blank = tblank;
                    end
                end
            endcase
        end
        return n;
    endfunction : chop_next

    // Gate pattern for a phase; drive polarity follows the sign of the target
    function automatic msic_pkg::msic_gates_s gates(
        input msic_pkg::msic_phase_e ph, input logic neg, input logic sr_n,
        input logic zero, input logic off
    );
        msic_pkg::msic_gates_s g;
        g = '0;
        if (!off) begin
            unique case (ph)
                msic_pkg::PH_DRIVE: begin
                    g.hs1 = !neg;
                    g.ls2 = !neg;
                    g.hs2 = neg;
                    g.ls1 = neg;
                end
                msic_pkg::PH_FAST: begin
                    if (!sr_n && !zero) begin
                        g.hs1 = neg;
                        g.ls2 = neg;
                        g.hs2 = !neg;
                        g.ls1 = !neg;
                    end
                end
                msic_pkg::PH_SLOW: begin
                    g.ls1 = 1'b1;
                    g.ls2 = 1'b1;
                end
                default: g = '0;
            endcase
        end
        return g;
    endfunction : gates

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        unique case (s_ff.ctrl[`MSIC_CTRL_RES_LO +: 2])
            2'h0: stride = 5'h08;
            2'h1: stride = 5'h04;
            2'h2: stride = 5'h02;
            default: stride = 5'h01;
        endcase
        dec_mode = decode_decay(s_ff.ctrl[`MSIC_CTRL_DEC_LO +: 2]);
        step_rise = i_step && !s_ff.step_d;
        // Low-power request freezes position and overcurrent latch, as the internal clock would
        hold_home = !i_indexer_clear_n || i_overcurrent_trip || i_overtemp_shutdown
            || i_supply_low_lockout;
        nxt_s.step_d = i_step;
        if (i_low_power_req_n) begin
            if (hold_home) begin
                nxt_s.pos = `MSIC_HOME_POS;
            end else if (step_rise) begin
                if (s_ff.ctrl[`MSIC_CTRL_DIR]) begin
                    nxt_s.pos = s_ff.pos + stride;
                end else begin
                    nxt_s.pos = s_ff.pos - stride;
                end
            end
            // Overcurrent clears only after the enable goes high then low
            if (i_overcurrent_trip) begin
                nxt_s.ocp_latch = 1'b1;
                nxt_s.en_seen_hi = 1'b0;
            end else if (s_ff.ocp_latch) begin
                if (i_output_on_n) begin
                    nxt_s.en_seen_hi = 1'b1;
                end else if (s_ff.en_seen_hi) begin
                    nxt_s.ocp_latch = 1'b0;
                end
            end
        end
        tgt_a = cos_at(nxt_s.pos);
        tgt_b = cos_at(nxt_s.pos - 5'h08);
        cur_a = cos_at(s_ff.pos);
        cur_b = cos_at(s_ff.pos - 5'h08);
        rising_a = tgt_a[7:0] > cur_a[7:0];
        rising_b = tgt_b[7:0] > cur_b[7:0];
        bridges_off = !i_low_power_req_n || hold_home || s_ff.ocp_latch
            || i_output_on_n;
        nxt_s.dac_a = tgt_a[7:0];
        nxt_s.dac_b = tgt_b[7:0];
        nxt_s.sgn_a = tgt_a[8];
        nxt_s.sgn_b = tgt_b[8];
        nxt_s.ch_a = chop_next(s_ff.ch_a, i_trip_a, i_zero_a, rising_a, bridges_off,
            s_ff.toff, s_ff.tblank, s_ff.tfast, dec_mode);
        nxt_s.ch_b = chop_next(s_ff.ch_b, i_trip_b, i_zero_b, rising_b, bridges_off,
            s_ff.toff, s_ff.tblank, s_ff.tfast, dec_mode);
        nxt_s.g_a = gates(nxt_s.ch_a.ph, tgt_a[8], s_ff.ctrl[`MSIC_CTRL_SR_N], i_zero_a,
            bridges_off);
        nxt_s.g_b = gates(nxt_s.ch_b.ph, tgt_b[8], s_ff.ctrl[`MSIC_CTRL_SR_N], i_zero_b,
            bridges_off);

        // ------------------------------------------------------------
        // Wishbone slave: one wait state, ack drops the cycle after
        // ------------------------------------------------------------
        wb_hit = i_wb_cyc && i_wb_stb && !s_ff.ack;
        nxt_s.ack = wb_hit;
        if (wb_hit && i_wb_we && i_wb_sel[0]) begin
            unique case (i_wb_adr)
                `MSIC_ADDR_CTRL: nxt_s.ctrl = i_wb_dat[7:0];
                `MSIC_ADDR_TOFF: nxt_s.toff[7:0] = i_wb_dat[7:0];
                `MSIC_ADDR_TBLANK: nxt_s.tblank[7:0] = i_wb_dat[7:0];
                `MSIC_ADDR_TFAST: nxt_s.tfast[7:0] = i_wb_dat[7:0];
                default: ;
            endcase
        end
        if (wb_hit && i_wb_we && i_wb_sel[1]) begin
            unique case (i_wb_adr)
                `MSIC_ADDR_TOFF: nxt_s.toff[15:8] = i_wb_dat[15:8];
                `MSIC_ADDR_TBLANK: nxt_s.tblank[15:8] = i_wb_dat[15:8];
                `MSIC_ADDR_TFAST: nxt_s.tfast[15:8] = i_wb_dat[15:8];
                default: ;
            endcase
        end
        nxt_s.rdat = 32'h0;
        if (wb_hit && !i_wb_we) begin
            unique case (i_wb_adr)
                `MSIC_ADDR_CTRL: nxt_s.rdat = {24'h0, s_ff.ctrl};
                `MSIC_ADDR_STAT: nxt_s.rdat = {16'h0, s_ff.ch_b.ph, s_ff.ch_a.ph,
                    s_ff.ocp_latch, bridges_off, 1'b0, s_ff.pos};
                `MSIC_ADDR_TOFF: nxt_s.rdat = {16'h0, s_ff.toff};
                `MSIC_ADDR_TBLANK: nxt_s.rdat = {16'h0, s_ff.tblank};
                `MSIC_ADDR_TFAST: nxt_s.rdat = {16'h0, s_ff.tfast};
                default: nxt_s.rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_ff <= '0;
            s_ff.pos <= `MSIC_HOME_POS;
            s_ff.ctrl <= `MSIC_CTRL_RESET;
            s_ff.toff <= 16'(`MSIC_TOFF_CYC);
            s_ff.tblank <= 16'(`MSIC_TBLANK_CYC);
            s_ff.tfast <= 16'(`MSIC_TFAST_CYC);
            s_ff.ch_a.ph <= msic_pkg::PH_IDLE;
            s_ff.ch_b.ph <= msic_pkg::PH_IDLE;
            s_ff.dac_a <= 8'h47;
            s_ff.dac_b <= 8'h47;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_wb_ack = s_ff.ack;
    assign o_wb_dat = s_ff.rdat;
    assign o_at_origin_flag_n = (s_ff.pos != `MSIC_HOME_POS);
    assign o_winding_a_outputs = s_ff.g_a;
    assign o_winding_b_outputs = s_ff.g_b;
    assign o_bridge_float = i_output_on_n;
    assign o_dac_a = s_ff.dac_a;
    assign o_dac_b = s_ff.dac_b;
    assign o_sign_a = s_ff.sgn_a;
    assign o_sign_b = s_ff.sgn_b;
endmodule : msic_core

/* msic_regs.svh */
// Register map, field positions, reset values and timing counts of the microstep indexer
// What this block does
// - Resolution code picks full, half, quarter, eighth
// - Each step rising edge moves one position
// - Direction high counts up, low counts down
// - Home is 45 degrees at reset
// - Home flag low only at home
// - 32-entry sine table, coarser modes skip entries
// - Position gives per-winding DAC code
// - Drive until trip, then fixed off-time
// - Ignore comparator during blanking after turn-on
// - Sync rectify: opposite FETs, stop near zero
// - No sync rectify: diodes only in fast
// - Slow decay: both low-sides on
// - Mixed: fast first, then slow
// - Rising target current always slow decay; code does so only for a trip in the same cycle as the step that raises it
// - Decay input level selects slow, fast, mixed
// - Overcurrent latches off, homes; enable toggle clears
// - Over-temperature shuts down, homes, auto resumes
// - Undervoltage disables, homes, auto resumes
// - Clear input homes, disables, ignores steps
// - Output enable low drives, high floats outputs
// - Indexer keeps running while outputs off
// - Sleep disables bridges, ignores inputs
`ifndef MSIC_REGS_SVH
`define MSIC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MSIC_ADDR_CTRL 8'h00
`define MSIC_ADDR_STAT 8'h04
`define MSIC_ADDR_TOFF 8'h08
`define MSIC_ADDR_TBLANK 8'h0c
`define MSIC_ADDR_TFAST 8'h10

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define MSIC_CTRL_RES_LO 0
`define MSIC_CTRL_DIR 2
`define MSIC_CTRL_SR_N 3
`define MSIC_CTRL_DEC_LO 4
`define MSIC_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MSIC_CLK_MHZ 40
`define MSIC_TOFF_US 38
`define MSIC_TBLANK_NS 950
`define MSIC_TFAST_US 10
`define MSIC_TOFF_CYC (`MSIC_TOFF_US * `MSIC_CLK_MHZ)
`define MSIC_TBLANK_CYC ((`MSIC_TBLANK_NS * `MSIC_CLK_MHZ + 999) / 1000)
`define MSIC_TFAST_CYC (`MSIC_TFAST_US * `MSIC_CLK_MHZ)
`define MSIC_HOME_POS 5'h04
`endif

/* msic_pkg.sv */
// Types shared by the microstep indexer
package msic_pkg;
    typedef enum logic [1:0] {
        DEC_SLOW = 2'h0,
        DEC_FAST = 2'h1,
        DEC_MIXED = 2'h2
    } msic_decay_e;

    typedef enum logic [3:0] {
        PH_DRIVE = 4'h1,
        PH_FAST = 4'h2,
        PH_SLOW = 4'h4,
        PH_IDLE = 4'h8
    } msic_phase_e;

    // Four gates of one H-bridge: high and low side of each leg
    typedef struct packed {
        logic hs1;
        logic ls1;
        logic hs2;
        logic ls2;
    } msic_gates_s;

    typedef struct packed {
        msic_phase_e ph;
        logic [15:0] tmr;
        logic [15:0] blank;
    } msic_chop_s;

    typedef struct packed {
        logic [4:0] pos;
        logic step_d;
        logic ocp_latch;
        logic en_seen_hi;
        logic [7:0] ctrl;
        logic [15:0] toff;
        logic [15:0] tblank;
        logic [15:0] tfast;
        logic ack;
        logic [31:0] rdat;
        msic_chop_s ch_a;
        msic_chop_s ch_b;
        msic_gates_s g_a;
        msic_gates_s g_b;
        logic [7:0] dac_a;
        logic [7:0] dac_b;
        logic sgn_a;
        logic sgn_b;
    } msic_state_s;
endpackage : msic_pkg

/* msic_step_ctl.sv */
// Motion controller model that issues one step pulse per request
`timescale 1ns/10ps
module msic_step_ctl #(
    parameter int WIDTH = 4,
    parameter int WAKE = 8
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic i_awake,
    output logic o_step,
    output logic o_done
);
    int cnt;
    int hold;
    // High and low phases last WIDTH cycles each, so one request gives one clean edge
    assign o_step = cnt > WIDTH;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= 0;
            hold <= WAKE;
            o_done <= 1'b0;
        end else begin
            hold <= !i_awake ? WAKE : (hold > 0) ? hold - 1 : 0;
            o_done <= cnt == 1;
            if (cnt > 0) begin
                cnt <= cnt - 1;
            end else if (i_req && !o_done && hold == 0) begin
                cnt <= 2 * WIDTH;
            end
        end
    end
endmodule : msic_step_ctl

/* msic_core_sva.sv */
// Concurrent checks on the ports of the microstep indexer core
`timescale 1ns/10ps
module msic_core_sva (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_indexer_clear_n,
    input wire logic i_output_on_n,
    input wire logic i_low_power_req_n,
    input wire logic i_step,
    input wire logic i_overcurrent_trip,
    input wire logic i_overtemp_shutdown,
    input wire logic i_supply_low_lockout,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic o_at_origin_flag_n,
    input wire msic_pkg::msic_gates_s o_winding_a_outputs,
    input wire msic_pkg::msic_gates_s o_winding_b_outputs,
    input wire logic o_bridge_float
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic flt;
    logic off;
    logic bad;
    assign flt = i_overcurrent_trip | i_overtemp_shutdown | i_supply_low_lockout;
    assign off = (o_winding_a_outputs == 4'h0) && (o_winding_b_outputs == 4'h0);
    assign bad = o_winding_a_outputs.ls1 & o_winding_a_outputs.ls2
        & (o_winding_a_outputs.hs1 | o_winding_a_outputs.hs2);
    // An edge is taken when the sample that sees step high is awake; this sequence asks both
    sequence step_edge;
        (!i_step && i_low_power_req_n) ##1 (i_step && i_low_power_req_n);
    endsequence
    sequence homed_step;
        step_edge ##0 (i_indexer_clear_n && !flt && !o_at_origin_flag_n);
    endsequence
    wb_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus request not answered in the next cycle");
    wb_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("bus answer held longer than one cycle");
    float_copy_a: assert property (o_bridge_float == i_output_on_n)
        else $error("float flag does not follow the enable input");
    float_off_a: assert property (i_output_on_n [*2] |-> off)
        else $error("gates driven while outputs are disabled");
    clear_home_a: assert property (
        (!i_indexer_clear_n && i_low_power_req_n) [*2] |-> off && !o_at_origin_flag_n)
        else $error("clear did not home the indexer and stop the bridges");
    sleep_off_a: assert property (!i_low_power_req_n [*2] |-> off)
        else $error("gates driven while asleep");
    fault_home_a: assert property (
        (flt && i_low_power_req_n) [*2] |-> off && !o_at_origin_flag_n)
        else $error("fault did not home the indexer and stop the bridges");
    step_leave_a: assert property (homed_step |=> o_at_origin_flag_n)
        else $error("step from home did not raise the home flag");
    slow_shape_a: assert property (!bad)
        else $error("high side on while both low sides recirculate");
endmodule : msic_core_sva
bind msic_core msic_core_sva msic_core_sva_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_indexer_clear_n(i_indexer_clear_n), .i_output_on_n(i_output_on_n),
    .i_low_power_req_n(i_low_power_req_n), .i_step(i_step),
    .i_overcurrent_trip(i_overcurrent_trip), .i_overtemp_shutdown(i_overtemp_shutdown),
    .i_supply_low_lockout(i_supply_low_lockout), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .o_at_origin_flag_n(o_at_origin_flag_n),
    .o_winding_a_outputs(o_winding_a_outputs), .o_winding_b_outputs(o_winding_b_outputs),
    .o_bridge_float(o_bridge_float));

/* msic_core_tb.sv */
// Self-checking testbench for the microstep indexer core
`timescale 1ns/10ps
module msic_core_tb;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic clr_n = 1'b1;
    logic on_n = 1'b0;
    logic wake_n = 1'b1;
    logic tb_step = 1'b0;
    logic req = 1'b0;
    logic [2:0] flt = 3'h0;
    logic [1:0] trip = 2'h0;
    logic [1:0] zero = 2'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat, rv;
    logic [7:0] dac_a, dac_b;
    logic ack, home_n, fl, sg_a, sg_b, c_step, c_done;
    msic_pkg::msic_gates_s ga, gb;
    int fail_count = 0;
    int comparisons = 0;
    int m[9] = '{100, 98, 92, 83, 71, 56, 38, 20, 0};
    logic [7:0] ra[5] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h20};
    logic [31:0] re[5] = '{32'h0, 32'h5f0, 32'h26, 32'h190, 32'h0};
    always #12.5 i_clk = ~i_clk;
    msic_core msic_core_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_indexer_clear_n(clr_n),
        .i_output_on_n(on_n), .i_low_power_req_n(wake_n), .i_step(c_step | tb_step),
        .i_overcurrent_trip(flt[0]), .i_overtemp_shutdown(flt[1]), .i_supply_low_lockout(flt[2]),
        .i_trip_a(trip[0]), .i_trip_b(trip[1]), .i_zero_a(zero[0]), .i_zero_b(zero[1]),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .o_at_origin_flag_n(home_n),
        .o_winding_a_outputs(ga), .o_winding_b_outputs(gb), .o_bridge_float(fl),
        .o_dac_a(dac_a), .o_dac_b(dac_b), .o_sign_a(sg_a), .o_sign_b(sg_b));
    msic_step_ctl msic_step_ctl_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req),
        .i_awake(wake_n), .o_step(c_step), .o_done(c_done));
    // ------------------------------------------------------------
    // Bus, step and compare helpers
    // ------------------------------------------------------------
    function automatic int mag(input int p);
        int k;
        k = p % 16;
        return (k <= 8) ? m[k] : m[16 - k];
    endfunction : mag
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge i_clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask : wb
    task automatic step1;
        int n;
        n = 0;
        req <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (c_done !== 1'b1 && n < 60);
        req <= 1'b0;
        @(posedge i_clk);
    endtask : step1
    task automatic chk_pos(input int p);
        int q;
        q = (p + 24) % 32;
        wb(1'b0, 8'h04, 32'h0, rv);
        chk("pos", p, rv[4:0]);
        chk("dac_a", mag(p), dac_a);
        chk("dac_b", mag(q), dac_b);
        chk("home_n", p != 4, home_n);
        if (mag(p) != 0) chk("sign_a", p > 8 && p < 24, sg_a);
        if (mag(q) != 0) chk("sign_b", q > 8 && q < 24, sg_b);
    endtask : chk_pos
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        int p;
        int s;
        tick(10);
        i_rstn <= 1'b1;
        tick(1);
        chk_pos(4);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ra[i], 32'h0, rv);
            chk("reg", re[i], rv);
        end
        wb(1'b1, 8'h04, 32'h1f, rv);
        chk_pos(4);
        wb(1'b1, 8'h08, 32'd20, rv);
        wb(1'b1, 8'h0c, 32'd4, rv);
        wb(1'b1, 8'h10, 32'd8, rv);
        for (int r = 0; r < 4; r++) begin
            s = 8 >> r;
            on_n <= (r == 1);
            clr_n <= 1'b0;
            step1;
            clr_n <= 1'b1;
            p = 4;
            wb(1'b1, 8'h00, 32'h4 | r, rv);
            for (int k = 0; k < 8; k++) begin
                if (k == 3) wb(1'b1, 8'h00, r, rv);
                step1;
                p = (k < 3) ? (p + s) % 32 : (p + 32 - s) % 32;
                chk_pos(p);
            end
            chk("float", r == 1, fl);
        end
        for (int f = 0; f < 3; f++) begin
            step1;
            flt[f] <= 1'b1;
            tick(3);
            flt[f] <= 1'b0;
            tick(2);
            chk_pos(4);
            chk("ocp", f == 0, rv[7]);
            on_n <= 1'b1;
            tick(2);
            on_n <= 1'b0;
            tick(2);
            wb(1'b0, 8'h04, 32'h0, rv);
            chk("ocp_clr", 0, rv[7]);
        end
        step1;
        wake_n <= 1'b0;
        tick(2);
        tb_step <= 1'b1;
        tick(4);
        tb_step <= 1'b0;
        tick(4);
        wake_n <= 1'b1;
        tick(2);
        chk_pos(3);
        step1;
        chk_pos(2);
        wb(1'b1, 8'h00, 32'h0, rv);
        tick(30);
        wb(1'b0, 8'h04, 32'h0, rv);
        chk("ph_a", msic_pkg::PH_DRIVE, rv[11:8]);
        trip[0] <= 1'b1;
        tick(6);
        wb(1'b0, 8'h04, 32'h0, rv);
        chk("ph_a", msic_pkg::PH_SLOW, rv[11:8]);
        chk("gates_a", 4'h5, ga);
        trip[0] <= 1'b0;
        tick(25);
        wb(1'b0, 8'h04, 32'h0, rv);
        chk("ph_a", msic_pkg::PH_DRIVE, rv[11:8]);
        chk("gates_a", 4'h9, ga);
        chk("gates_b", 4'h9, gb);
        wb(1'b1, 8'h00, 32'h10, rv);
        trip[0] <= 1'b1;
        tick(3);
        chk("gates_a", 4'h6, ga);
        zero[0] <= 1'b1;
        tick(2);
        chk("gates_a", 4'h0, ga);
        zero[0] <= 1'b0;
        wb(1'b1, 8'h00, 32'h18, rv);
        chk("gates_a", 4'h0, ga);
        wb(1'b1, 8'h00, 32'h20, rv);
        tick(18);
        wb(1'b0, 8'h04, 32'h0, rv);
        chk("ph_a", msic_pkg::PH_FAST, rv[11:8]);
        tick(4);
        wb(1'b0, 8'h04, 32'h0, rv);
        chk("ph_a", msic_pkg::PH_SLOW, rv[11:8]);
        trip[0] <= 1'b0;
        final_report;
    end
    // The tests take about 800 cycles; twenty-five times that means a hang
    initial begin
        tick(20000);
        fail_count++;
        final_report;
    end
endmodule : msic_core_tb
